// >>> hw/wdt_params.svh
// constants of the watchdog: register offsets, field positions, resets, timing
// assumes a 32-bit apb slave port with byte addresses
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
// ==========================================================
// register byte offsets
`define WDT_OFF_CTRL      8'h00
`define WDT_OFF_COUNT     8'h04
`define WDT_OFF_CKSEL     8'h08
`define WDT_OFF_IRQ_STAT  8'h0C
`define WDT_OFF_IRQ_MASK  8'h10
// ==========================================================
// control/status field positions
`define WDT_CTL_CNT_INH   7
`define WDT_CTL_CNT_WE    6
`define WDT_CTL_CTL_INH   5
`define WDT_CTL_CTL_WE    4
`define WDT_CTL_RUN_INH   3
`define WDT_CTL_RUN       2
`define WDT_CTL_FLAG_INH  1
`define WDT_CTL_FLAG      0
// ==========================================================
// interrupt status positions
`define WDT_IRQ_OVF       0
`define WDT_IRQ_RST_END   1
// ==========================================================
// reset values and fixed read values
`define WDT_CKSEL_RESET   4'hF
`define WDT_CKSEL_RSVD    4'hF
`define WDT_COUNT_RESET   8'h00
`define WDT_COUNT_MAX     8'hFF
// ==========================================================
// timing
`define WDT_RST_OSC_CYCLES 256
`define WDT_PRESC_MIN_LOG  6
`define WDT_PRESC_W        13
`endif

// >>> hw/wdt_pkg.sv
// types shared by the watchdog design
// assumes wdt_params.svh is on the include path
`include "wdt_params.svh"
package wdt_pkg;
    typedef enum logic [2:0] {
        SEL_CTRL  = 3'b000,
        SEL_COUNT = 3'b001,
        SEL_CKSEL = 3'b010,
        SEL_ISTAT = 3'b011,
        SEL_IMASK = 3'b100,
        SEL_NONE  = 3'b111
    } reg_sel_e;

    typedef struct packed {
        logic [`WDT_PRESC_W-1:0] presc;
        logic                    osc_s1;
        logic                    osc_s2;
        logic                    osc_s3;
        logic                    pin_s1;
        logic                    pin_s2;
        logic [7:0]              count;
        logic [3:0]              cksel;
        logic                    cnt_we;
        logic                    ctl_we;
        logic                    run;
        logic                    flag;
        logic                    rst_act;
        logic [7:0]              rst_cnt;
        logic [1:0]              irq_stat;
        logic [1:0]              irq_mask;
        logic [31:0]             prdata;
    } wdt_state_s;
endpackage

// >>> hw/watchdog.sv
// watchdog: 8-bit up-counter with protected start and overflow reset pulse
// assumes apb master on sys_clk_in; osc clock and reset pin are asynchronous
// and much slower than sys_clk_in (at most a quarter of its rate)
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

// Notes on behaviour
// - 8-bit counter advances on selected input clock
// - clock-select bits 7..4 read one, ignore writes
// - clock-select field 3..0 read/write, resets ones
// - codes 1000..1111 pick clk/64..8192, 0xxx oscillator
// - run set needs inhibit zero, enable already set
// - tick at ff overflows, raises internal reset
// - internal reset lasts 256 oscillator cycles
// - written count becomes new start value
// - overflow sets flag, counter wraps to zero
// - enable changes only with inhibit zero; inhibit reads one
// - counter writable only while counter enable set
// - run and flag cleared by pin or write
module watchdog
    import wdt_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    input  wire logic        osc_clk_in,
    input  wire logic        external_reset_pin_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    output logic             wdt_reset_out,
    output logic             irq_out
);
    // ==========================================================
    // address decode
    function automatic reg_sel_e decode(input logic [7:0] addr);
        case (addr)
            `WDT_OFF_CTRL:     decode = SEL_CTRL;
            `WDT_OFF_COUNT:    decode = SEL_COUNT;
            `WDT_OFF_CKSEL:    decode = SEL_CKSEL;
            `WDT_OFF_IRQ_STAT: decode = SEL_ISTAT;
            `WDT_OFF_IRQ_MASK: decode = SEL_IMASK;
            default:           decode = SEL_NONE;
        endcase
    endfunction

    // ==========================================================
    // input clock choice
    function automatic logic sel_tick(
        input logic [3:0]              cks,
        input logic [`WDT_PRESC_W-1:0] presc,
        input logic                    osc_edge
    );
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < `WDT_PRESC_W; i++) begin
            if (i < `WDT_PRESC_MIN_LOG + int'(cks[2:0])) begin
                ok = ok & presc[i];
            end
        end
        sel_tick = cks[3] ? ok : osc_edge;
    endfunction

    localparam wdt_state_s RESET_STATE = '{
        cksel:   `WDT_CKSEL_RESET,
        count:   `WDT_COUNT_RESET,
        default: '0
    };

    // last pulse count; the 256th oscillator edge ends the reset
    localparam logic [7:0] RST_LAST = 8'(`WDT_RST_OSC_CYCLES - 1);

    wdt_state_s q;
    wdt_state_s d;
    reg_sel_e   sel;
    logic       wr_en;
    logic       setup;
    logic       osc_edge;
    logic       tick;
    logic       cnt_wr;
    logic       ovf;
    logic       rst_end;
    logic [7:0] ctl_view;

    assign sel      = decode(paddr_in);
    assign wr_en    = psel_in & penable_in & pwrite_in;
    assign setup    = psel_in & ~penable_in;
    // second and third stages only; first stage feeds nothing else
    assign osc_edge = q.osc_s2 & ~q.osc_s3;
    assign tick     = sel_tick(q.cksel, q.presc, osc_edge);
    assign cnt_wr   = wr_en & (sel == SEL_COUNT) & q.cnt_we;
    assign ovf      = q.run & tick & (q.count == `WDT_COUNT_MAX) & ~cnt_wr;
    assign rst_end  = q.rst_act & osc_edge & (q.rst_cnt == RST_LAST) & ~ovf;
    // inhibit bits always read one
    assign ctl_view = {1'b1, q.cnt_we, 1'b1, q.ctl_we,
                       1'b1, q.run, 1'b1, q.flag};

    // ==========================================================
    // next state
    always_comb begin
        d = q;
        d.presc  = q.presc + `WDT_PRESC_W'(1);
        d.osc_s1 = osc_clk_in;
        d.osc_s2 = q.osc_s1;
        d.osc_s3 = q.osc_s2;
        d.pin_s1 = external_reset_pin_in;
        d.pin_s2 = q.pin_s1;

        // counter: a software load wins over a tick in the same cycle
        if (cnt_wr) begin
            d.count = pwdata_in[7:0];
        end else if (q.run && tick) begin
            d.count = q.count + 8'h01;
        end

        // control/status, each field guarded by its inhibit bit
        if (wr_en && sel == SEL_CTRL) begin
            if (!pwdata_in[`WDT_CTL_CNT_INH]) begin
                d.cnt_we = pwdata_in[`WDT_CTL_CNT_WE];
            end
            if (!pwdata_in[`WDT_CTL_CTL_INH]) begin
                d.ctl_we = pwdata_in[`WDT_CTL_CTL_WE];
            end
            // old enable value: start needs two writes
            if (q.ctl_we && !pwdata_in[`WDT_CTL_RUN_INH]) begin
                d.run = pwdata_in[`WDT_CTL_RUN];
            end
            if (q.ctl_we && !pwdata_in[`WDT_CTL_FLAG_INH]) begin
                // software may only clear the flag
                d.flag = q.flag & pwdata_in[`WDT_CTL_FLAG];
            end
        end
        if (ovf) begin
            d.flag = 1'b1;
        end
        if (q.pin_s2) begin
            d.run  = 1'b0;
            d.flag = 1'b0;
        end

        if (wr_en && sel == SEL_CKSEL) begin
            d.cksel = pwdata_in[3:0];
        end

        // internal reset pulse counted in oscillator edges
        if (ovf) begin
            d.rst_act = 1'b1;
            d.rst_cnt = 8'h00;
        end else if (q.rst_act && osc_edge) begin
            d.rst_cnt = q.rst_cnt + 8'h01;
            if (q.rst_cnt == RST_LAST) begin
                d.rst_act = 1'b0;
            end
        end

        // interrupt status: write one clears, new event wins
        if (wr_en && sel == SEL_ISTAT) begin
            d.irq_stat = q.irq_stat & ~pwdata_in[1:0];
        end
        d.irq_stat[`WDT_IRQ_OVF]     = d.irq_stat[`WDT_IRQ_OVF] | ovf;
        d.irq_stat[`WDT_IRQ_RST_END] = d.irq_stat[`WDT_IRQ_RST_END] | rst_end;
        if (wr_en && sel == SEL_IMASK) begin
            d.irq_mask = pwdata_in[1:0];
        end

        // read data captured in setup, presented in access
        if (setup) begin
            case (sel)
                SEL_CTRL:  d.prdata = {24'h00_0000, ctl_view};
                SEL_COUNT: d.prdata = {24'h00_0000, q.count};
                SEL_CKSEL: d.prdata = {24'h00_0000, `WDT_CKSEL_RSVD, q.cksel};
                SEL_ISTAT: d.prdata = {30'h0000_0000, q.irq_stat};
                SEL_IMASK: d.prdata = {30'h0000_0000, q.irq_mask};
                default:   d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (reset_in) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign prdata_out    = q.prdata;
    // zero wait states; unmapped addresses answer with an error
    assign pready_out    = 1'b1;
    assign pslverr_out   = psel_in & penable_in & (sel == SEL_NONE);
    assign wdt_reset_out = q.rst_act;
    assign irq_out       = |(q.irq_stat & q.irq_mask);

    // ==========================================================
    // checks
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    count_step_a: assert property (
        q.run && tick && !cnt_wr && q.count != 8'hFF
        |=> q.count == $past(q.count) + 8'h01)
        else $error("counter did not advance on tick");

    cksel_rsvd_a: assert property (
        setup && sel == SEL_CKSEL |=> prdata_out[7:4] == 4'hF)
        else $error("clock select upper bits not ones");

    cksel_reset_a: assert property (
        $past(reset_in) |-> q.cksel == 4'hF)
        else $error("clock select not all ones after reset");

    div64_tick_a: assert property (
        q.cksel == 4'b1000 && q.run && !cnt_wr && q.count != 8'hFF
        && q.presc[5:0] != 6'h3F |=> q.count == $past(q.count))
        else $error("counter moved off the divide-by-64 tick");

    run_start_a: assert property (
        $rose(q.run) |-> $past(q.ctl_we) && $past(wr_en))
        else $error("run set without prior enable");

    ovf_wrap_a: assert property (
        ovf |=> q.count == 8'h00 && q.flag && wdt_reset_out)
        else $error("overflow did not wrap and raise reset");

    rst_len_a: assert property (
        rst_end |=> !wdt_reset_out)
        else $error("internal reset did not end after 256 cycles");

    rst_hold_a: assert property (
        wdt_reset_out && q.rst_cnt != RST_LAST |=> wdt_reset_out)
        else $error("internal reset ended early");

    cnt_load_a: assert property (
        cnt_wr |=> q.count == $past(pwdata_in[7:0]))
        else $error("counter load lost");

    enable_guard_a: assert property (
        $changed(q.ctl_we) |-> $past(wr_en) && $past(sel == SEL_CTRL)
        && !$past(pwdata_in[`WDT_CTL_CTL_INH]))
        else $error("control enable changed without inhibit zero");

    cnt_guard_a: assert property (
        wr_en && sel == SEL_COUNT && !q.cnt_we && !(q.run && tick)
        |=> $stable(q.count))
        else $error("counter written while write disabled");

    pin_clear_a: assert property (
        q.pin_s2 |=> !q.run && !q.flag)
        else $error("reset pin did not clear run and flag");

    halt_hold_a: assert property (
        !q.run && !cnt_wr |=> $stable(q.count))
        else $error("stopped counter changed");

    // ==========================================================
    // flag, run, enable, select, tick, pulse and interrupt checks
    flag_source_a: assert property (
        $rose(q.flag) |-> $past(ovf))
        else $error("reset flag set without overflow");

    // an overflow in the same cycle keeps the flag set
    flag_clear_a: assert property (
        wr_en && sel == SEL_CTRL && q.ctl_we && !pwdata_in[`WDT_CTL_FLAG_INH]
        && !pwdata_in[`WDT_CTL_FLAG] && !ovf |=> !q.flag)
        else $error("reset flag not cleared by write");

    run_clear_a: assert property (
        $fell(q.run) |-> $past(q.pin_s2) || ($past(wr_en) && $past(sel == SEL_CTRL)
        && $past(q.ctl_we) && !$past(pwdata_in[`WDT_CTL_RUN_INH])))
        else $error("run cleared without pin or guarded write");

    run_hold_a: assert property (
        q.run && !q.pin_s2 && !(wr_en && sel == SEL_CTRL) |=> q.run)
        else $error("run dropped on its own");

    cnt_we_guard_a: assert property (
        $changed(q.cnt_we) |-> $past(wr_en) && $past(sel == SEL_CTRL)
        && !$past(pwdata_in[`WDT_CTL_CNT_INH]))
        else $error("counter enable changed without inhibit zero");

    ctl_read_a: assert property (
        setup && sel == SEL_CTRL |=> prdata_out[7] && prdata_out[5]
        && prdata_out[3] && prdata_out[1])
        else $error("inhibit bits not read as one");

    cksel_write_a: assert property (
        wr_en && sel == SEL_CKSEL |=> q.cksel == $past(pwdata_in[3:0]))
        else $error("clock select write lost");

    // oscillator mode moves only on a synchronised rising edge
    osc_tick_a: assert property (
        !q.cksel[3] && q.run && !cnt_wr && !osc_edge |=> $stable(q.count))
        else $error("counter moved without an oscillator edge");

    div8192_tick_a: assert property (
        q.cksel == 4'b1111 && q.run && !cnt_wr && q.presc != 13'h1FFF
        |=> q.count == $past(q.count))
        else $error("counter moved off the divide-by-8192 tick");

    load_wins_a: assert property (
        cnt_wr |=> !$rose(wdt_reset_out))
        else $error("software load still overflowed");

    rst_source_a: assert property (
        $rose(wdt_reset_out) |-> $past(ovf))
        else $error("internal reset raised without overflow");

    rst_start_a: assert property (
        ovf |=> q.rst_cnt == 8'h00)
        else $error("pulse count not restarted on overflow");

    rst_step_a: assert property (
        wdt_reset_out && osc_edge && !ovf && q.rst_cnt != RST_LAST
        |=> q.rst_cnt == $past(q.rst_cnt) + 8'h01)
        else $error("pulse count missed an oscillator edge");

    irq_ovf_a: assert property (
        ovf |=> q.irq_stat[`WDT_IRQ_OVF])
        else $error("overflow event not latched");

    irq_clear_a: assert property (
        wr_en && sel == SEL_ISTAT && pwdata_in[`WDT_IRQ_OVF] && !ovf
        |=> !q.irq_stat[`WDT_IRQ_OVF])
        else $error("overflow event not cleared by write");

    irq_end_a: assert property (
        rst_end |=> q.irq_stat[`WDT_IRQ_RST_END])
        else $error("pulse end event not latched");

    osc_seen_c: cover property (!q.cksel[3] && q.run && osc_edge);
    start_seen_c: cover property ($rose(q.run));
    ovf_seen_c: cover property (ovf);
    rst_done_c: cover property (rst_end);
    load_seen_c: cover property (cnt_wr);
endmodule // watchdog

`default_nettype wire

// >>> tb/watchdog_tb.sv
// self-checking bench for the watchdog: apb register access, protected start,
// overflow pulse, interrupts, prescaler codes and pin reset
// assumes zero-wait apb slave and an oscillator at 1/8 of the system clock
`timescale 1ns/10ps
`default_nettype none
`include "wdt_params.svh"

module watchdog_tb;
    logic        sys_clk_in  = 1'b0;
    logic        reset_in    = 1'b1;
    logic        osc_clk_in  = 1'b0;
    logic        pin_rst     = 1'b0;
    logic        psel_in     = 1'b0;
    logic        penable_in  = 1'b0;
    logic        pwrite_in   = 1'b0;
    logic [7:0]  paddr_in    = 8'h00;
    logic [31:0] pwdata_in   = 32'h0000_0000;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    logic        wdt_reset_out;
    logic        irq_out;
    logic [2:0]  osc_cnt     = 3'h0;
    int          cyc         = 0;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          t0;
    int          d;
    logic [31:0] r;
    logic        e;

    watchdog i_watchdog (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .osc_clk_in(osc_clk_in),
        .external_reset_pin_in(pin_rst), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .wdt_reset_out(wdt_reset_out), .irq_out(irq_out));

    // ==========================================================
    // clocks and timeout
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    // oscillator kept well below a quarter of the system rate
    always @(posedge sys_clk_in) begin
        osc_cnt    <= osc_cnt + 3'h1;
        osc_clk_in <= osc_cnt[2];
        cyc        <= cyc + 1;
        if (cyc == 90000) begin
            miscompares++;
            complete_run();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        psel_in    <= 1'b1;
        pwrite_in  <= w;
        paddr_in   <= a;
        pwdata_in  <= wd;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        @(posedge sys_clk_in);
        while (pready_out !== 1'b1) @(posedge sys_clk_in);
        rd = prdata_out;
        er = pslverr_out;
        psel_in    <= 1'b0;
        penable_in <= 1'b0;
        @(posedge sys_clk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] x;
        logic        y;
        apb(1'b1, a, v, x, y);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        logic y;
        apb(1'b0, a, 32'h0000_0000, v, y);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        check(v, exp);
    endtask

    task automatic wait_lvl(input logic lvl, input int lim);
        int k;
        k = 0;
        while (wdt_reset_out !== lvl && k < lim) begin
            @(posedge sys_clk_in);
            k++;
        end
    endtask

    // cycles between two successive counter steps; polling costs 3 cycles
    task automatic measure(output int dd);
        logic [31:0] a;
        logic [31:0] b;
        int          k;
        int          ts;
        rd(`WDT_OFF_COUNT, a);
        b = a;
        k = 0;
        while (b === a && k < 6000) begin
            rd(`WDT_OFF_COUNT, b);
            k++;
        end
        ts = cyc;
        a  = b;
        k  = 0;
        while (b === a && k < 6000) begin
            rd(`WDT_OFF_COUNT, b);
            k++;
        end
        dd = cyc - ts;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic reset_values();
        rc(`WDT_OFF_CKSEL, 32'h0000_00FF);
        rc(`WDT_OFF_COUNT, 32'h0000_0000);
        rc(`WDT_OFF_CTRL, 32'h0000_00AA);
        apb(1'b0, 8'h20, 32'h0000_0000, r, e);
        check({31'h0, e}, 32'h0000_0001);
        check(r, 32'h0000_0000);
        check({31'h0, pready_out}, 32'h0000_0001);
        apb(1'b0, `WDT_OFF_CKSEL, 32'h0000_0000, r, e);
        check({31'h0, e}, 32'h0000_0000);
        check(r, 32'h0000_00FF);
    endtask

    task automatic protection();
        wr(`WDT_OFF_CKSEL, 32'h0000_0000);
        rc(`WDT_OFF_CKSEL, 32'h0000_00F0);
        wr(`WDT_OFF_CTRL, 32'h0000_00E6);
        rc(`WDT_OFF_CTRL, 32'h0000_00AA);
        wr(`WDT_OFF_COUNT, 32'h0000_0055);
        rc(`WDT_OFF_COUNT, 32'h0000_0000);
        wr(`WDT_OFF_CTRL, 32'h0000_007F);
        wr(`WDT_OFF_CTRL, 32'h0000_00BF);
        rc(`WDT_OFF_CTRL, 32'h0000_00EA);
        wr(`WDT_OFF_COUNT, 32'h0000_00FD);
        rc(`WDT_OFF_COUNT, 32'h0000_00FD);
    endtask

    // protected start, three ticks of clk/64 to overflow, then the pulse
    task automatic overflow_pulse();
        wr(`WDT_OFF_CKSEL, 32'h0000_0008);
        wr(`WDT_OFF_IRQ_MASK, 32'h0000_0002);
        wr(`WDT_OFF_CTRL, 32'h0000_00DA);
        wr(`WDT_OFF_CTRL, 32'h0000_00D6);
        t0 = cyc;
        wait_lvl(1'b1, 400);
        check({31'h0, (cyc - t0 >= 125) && (cyc - t0 <= 200)}, 32'h0000_0001);
        // pulse length counted from its rise, not from after the reads
        t0 = cyc;
        rc(`WDT_OFF_COUNT, 32'h0000_0000);
        rc(`WDT_OFF_CTRL, 32'h0000_00FF);
        rc(`WDT_OFF_IRQ_STAT, 32'h0000_0001);
        check({31'h0, irq_out}, 32'h0000_0000);
        wait_lvl(1'b0, 2200);
        check({31'h0, (cyc - t0 >= 2036) && (cyc - t0 <= 2056)}, 32'h0000_0001);
        rc(`WDT_OFF_IRQ_STAT, 32'h0000_0003);
        check({31'h0, irq_out}, 32'h0000_0001);
        wr(`WDT_OFF_IRQ_STAT, 32'h0000_0003);
        rc(`WDT_OFF_IRQ_STAT, 32'h0000_0000);
        check({31'h0, irq_out}, 32'h0000_0000);
    endtask

    // flag clear, then stop holds a loaded count
    task automatic stop_hold();
        wr(`WDT_OFF_CTRL, 32'h0000_00FC);
        rc(`WDT_OFF_CTRL, 32'h0000_00FE);
        wr(`WDT_OFF_CTRL, 32'h0000_00F2);
        rc(`WDT_OFF_CTRL, 32'h0000_00FA);
        wr(`WDT_OFF_COUNT, 32'h0000_0042);
        repeat (200) @(posedge sys_clk_in);
        rc(`WDT_OFF_COUNT, 32'h0000_0042);
    endtask

    // oscillator code 0000 first, then every prescaler code 1000..1111
    task automatic clock_codes();
        wr(`WDT_OFF_CTRL, 32'h0000_00D6);
        wr(`WDT_OFF_CKSEL, 32'h0000_0000);
        measure(d);
        check({31'h0, (d >= 4) && (d <= 12)}, 32'h0000_0001);
        for (int c = 8; c < 16; c++) begin
            wr(`WDT_OFF_CKSEL, 32'(c));
            measure(d);
            check({31'h0, (d >= (1 << (c - 2)) - 4) && (d <= (1 << (c - 2)) + 4)},
                  32'h0000_0001);
        end
    endtask

    // pin reset clears run and flag only
    task automatic pin_reset();
        pin_rst <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        pin_rst <= 1'b0;
        @(posedge sys_clk_in);
        rc(`WDT_OFF_CTRL, 32'h0000_00FA);
    endtask

    // a reset with the counter stopped brings select, counter and enables back
    task automatic mid_reset();
        wr(`WDT_OFF_CKSEL, 32'h0000_0009);
        reset_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        @(posedge sys_clk_in);
        rc(`WDT_OFF_CKSEL, 32'h0000_00FF);
        rc(`WDT_OFF_COUNT, 32'h0000_0000);
        rc(`WDT_OFF_CTRL, 32'h0000_00AA);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (10) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        @(posedge sys_clk_in);
        reset_values();
        protection();
        overflow_pulse();
        stop_hold();
        clock_codes();
        pin_reset();
        mid_reset();
        complete_run();
    end
endmodule // watchdog_tb

`default_nettype wire
